/* src/pmc_defines.svh */
// Register offsets, field positions, reset values and timing counts of the power mode controller
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define PMC_A_MODE 8'h00
`define PMC_A_ACT_TMPL 8'h04
`define PMC_A_ALT_TMPL 8'h08
`define PMC_A_REG_CTL 8'h0c
`define PMC_A_TW_CTL 8'h10
`define PMC_A_TW_CNT 8'h14
`define PMC_A_STATUS 8'h18
`define PMC_A_INT_STAT 8'h1c
`define PMC_A_INT_CLR 8'h20
`define PMC_A_INT_EN 8'h24

// ----------------------------------------------------------------
// Mode codes, widths and field positions
// ----------------------------------------------------------------
`define PMC_MODE_ACT 2'h0
`define PMC_MODE_ALT 2'h1
`define PMC_MODE_SLEEP 2'h2
`define PMC_MODE_HIB 2'h3
`define PMC_NRES 8
`define PMC_CPU_BIT 0
`define PMC_NWAKE 5
`define PMC_WAKE_PIU 1
`define PMC_TW_W 13
`define PMC_TW_RST_BIT 5
`define PMC_TW_EN_BIT 4
`define PMC_NINT 3
`define PMC_INT_SLP_WAKE 0
`define PMC_INT_HIB_WAKE 1
`define PMC_INT_TW_TICK 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PMC_RST_ACT_TMPL 8'hff
`define PMC_RST_ALT_TMPL 8'hfe
`define PMC_RST_REG_CTL 2'h3
`define PMC_RST_TW_CTL 5'h00
`define PMC_RST_INT_EN 3'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PMC_CLK_NS 10
`define PMC_SLP_WAKE_NS 15000
`define PMC_HIB_RESUME_NS 20000
`define PMC_SLP_WAKE_CYC ((`PMC_SLP_WAKE_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS)
`define PMC_HIB_RESUME_CYC (`PMC_HIB_RESUME_NS / `PMC_CLK_NS)
`define PMC_CNT_W 12

`endif

/* src/pmc_pkg.sv */
// Types shared by the power mode controller files
package pmc_pkg;

  // ----------------------------------------------------------------
  // Global power state machine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PMC_ACT,
    PMC_ALT,
    PMC_PEND,
    PMC_SLEEP,
    PMC_SWAKE,
    PMC_HIB,
    PMC_HWAKE
  } pmc_state_e;

  // ----------------------------------------------------------------
  // Per-resource power controls, bit 0 is the CPU
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] clk_en;
    logic [7:0] bias_en;
  } pmc_res_s;

endpackage : pmc_pkg

/* src/pmc_sync.sv */
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/100ps

module pmc_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // ----------------------------------------------------------------
  // Synchroniser flops, first stage is read only by the second
  // ----------------------------------------------------------------
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        meta_reg[i] <= 1'b0;
        q_reg[i] <= 1'b0;
      end else begin
        meta_reg[i] <= d_in[i];
        q_reg[i] <= meta_reg[i];
      end
    end
  end

  assign q_out = q_reg;

endmodule : pmc_sync

/* src/pmc_timewheel.sv */
// Free-running 13-bit timewheel stepped by the 1 kHz low-speed oscillator
`timescale 1ns/100ps
`include "pmc_defines.svh"

module pmc_timewheel (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic step_in,
  input wire logic run_in,
  input wire logic clear_in,
  input wire logic [3:0] tap_in,
  output logic [`PMC_TW_W-1:0] count_out,
  output logic tick_out
);

  logic [`PMC_TW_W-1:0] cnt_reg;
  logic [`PMC_TW_W-1:0] cnt_next;
  logic tick_reg;
  logic tick_next;
  logic [`PMC_TW_W-1:0] mask;

  // ----------------------------------------------------------------
  // Counter; stops while run is low, firmware clear wins over a step
  // ----------------------------------------------------------------
  always_comb begin
    mask = `PMC_TW_W'((14'h0002 << tap_in) - 14'h0001);
    cnt_next = cnt_reg;
    tick_next = 1'b0;
    if (clear_in) begin
      cnt_next = '0;
    end else if (run_in && step_in) begin
      cnt_next = cnt_reg + `PMC_TW_W'(1);
      // Tick when the selected low bits roll over to zero
      tick_next = &(cnt_reg | ~mask);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign count_out = cnt_reg;
  assign tick_out = tick_reg;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_tw_clear_zero: assert property (clear_in |=> cnt_reg == '0)
    else $error("Timewheel not cleared");
  a_tw_hold_stop: assert property (!run_in && !clear_in |=> $stable(cnt_reg))
    else $error("Timewheel moved while stopped");

endmodule : pmc_timewheel

/* src/pmc_power_mode_controller.sv */
// Global power mode controller: mode state machine, templates, wake logic, register port
`timescale 1ns/100ps
`include "pmc_defines.svh"

// Contract
// - Four global modes: active, alternate active, sleep, hibernate, in that rank.
// - In active mode each resource follows its active template bit.
// - A disabled resource has its clocks gated and its bias turned off.
// - Template bits may change anytime; the change applies at once.
// - CPU may switch itself off; the next wakeup turns it back on.
// - Any wakeup sets mode to active and enables CPU regardless of template.
// - After reset the mode is active.
// - Alternate active uses its own, usually smaller, template.
// - Active entered by wakeup, reset or write; any interrupt wakes.
// - Sleep disables most resources whatever the templates say.
// - Sleep keeps only low-speed clocks; six listed wake sources.
// - Wake from sleep waits a fixed 15 us before active.
// - Hibernate stops all clocks, keeps state; only pin interrupts wake it.
// - Core regulators on after power-up; software may turn them off.
// - Timewheel is a free 13-bit counter on the 1 kHz clock, firmware-resettable.
// - Hibernate resume to active finishes within 100 us.
module pmc_power_mode_controller (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic lso_clk_in,
  input wire logic cpu_idle_in,
  input wire logic irq_any_in,
  input wire logic [`PMC_NWAKE-1:0] wake_pin_in,
  input wire logic io_supply_valid_in,
  output logic [1:0] mode_out,
  output pmc_pkg::pmc_res_s res_out,
  output logic lso_run_out,
  output logic [1:0] core_reg_en_out,
  output logic irq_out
);

  pmc_pkg::pmc_state_e state_reg, state_next;
  logic [`PMC_CNT_W-1:0] cnt_reg, cnt_next;
  logic pend_hib_reg, pend_hib_next, base_alt_reg, base_alt_next;
  logic cpu_force_reg, cpu_force_next;
  logic [`PMC_NRES-1:0] act_tmpl_reg, act_tmpl_next, alt_tmpl_reg, alt_tmpl_next;
  logic [1:0] reg_ctl_reg, reg_ctl_next;
  logic [4:0] tw_ctl_reg, tw_ctl_next;
  logic [`PMC_NINT-1:0] int_stat_reg, int_stat_next, int_en_reg, int_en_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [`PMC_NRES-1:0] en_vec_reg, en_vec_next;
  logic [13:0] wake_len_reg, wake_len_next; // Check helper, kept apart from cnt_reg on purpose
  logic [`PMC_NWAKE-1:0] wake_sync;
  logic lso_sync, lso_dly_reg, lso_step, tw_tick, tw_clear;
  logic [`PMC_TW_W-1:0] tw_count;
  logic mode_wr, slp_wake, hib_wake;
  logic [1:0] mode_req;
  logic [`PMC_NINT-1:0] int_evt;

  // ----------------------------------------------------------------
  // Input synchronisers, timewheel and wake sources
  // ----------------------------------------------------------------
  // Wake pins and the oscillator clock come from other domains
  pmc_sync #(.W(`PMC_NWAKE + 1)) u_sync (.clk_in(clk_in), .rst_in(rst_in),
    .d_in({lso_clk_in, wake_pin_in}), .q_out({lso_sync, wake_sync}));

  // Rising edge of the synchronised 1 kHz clock steps the timewheel
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lso_dly_reg <= 1'b0;
    end else begin
      lso_dly_reg <= lso_sync;
    end
  end

  assign lso_step = lso_sync & ~lso_dly_reg;
  assign tw_clear = wr_in && addr_in == `PMC_A_TW_CTL && wdata_in[`PMC_TW_RST_BIT];

  // Timewheel halts in hibernate, where no clock runs
  pmc_timewheel u_tw (.clk_in(clk_in), .rst_in(rst_in), .step_in(lso_step),
    .run_in(lso_run_out), .clear_in(tw_clear), .tap_in(tw_ctl_reg[3:0]),
    .count_out(tw_count), .tick_out(tw_tick));

  // Comparator, pin unit, I2C match, RTC, voltage detector, timewheel
  assign slp_wake = (|wake_sync) | (tw_tick & tw_ctl_reg[`PMC_TW_EN_BIT]);
  assign hib_wake = wake_sync[`PMC_WAKE_PIU];
  assign mode_wr = wr_in && addr_in == `PMC_A_MODE;
  assign mode_req = wdata_in[1:0];

  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    pend_hib_next = pend_hib_reg;
    base_alt_next = base_alt_reg;
    cpu_force_next = cpu_force_reg;
    wake_len_next = state_reg inside {pmc_pkg::PMC_SWAKE, pmc_pkg::PMC_HWAKE} ?
      wake_len_reg + 14'h0001 : 14'h0000;
    // A fresh template write hands the CPU bit back to firmware
    if (wr_in && (addr_in == `PMC_A_ACT_TMPL || addr_in == `PMC_A_ALT_TMPL)) begin
      cpu_force_next = 1'b0;
    end
    case (state_reg)
      pmc_pkg::PMC_ACT, pmc_pkg::PMC_ALT: begin
        if (irq_any_in) begin
          state_next = pmc_pkg::PMC_ACT;
          cpu_force_next = 1'b1;
        end else if (mode_wr) begin
          case (mode_req)
            `PMC_MODE_ACT: state_next = pmc_pkg::PMC_ACT;
            `PMC_MODE_ALT: state_next = pmc_pkg::PMC_ALT;
            default: begin
              // Entry is held until the CPU reports idle
              state_next = pmc_pkg::PMC_PEND;
              pend_hib_next = mode_req == `PMC_MODE_HIB;
              base_alt_next = state_reg == pmc_pkg::PMC_ALT;
            end
          endcase
        end
      end
      pmc_pkg::PMC_PEND: begin
        if (irq_any_in) begin
          state_next = pmc_pkg::PMC_ACT;
          cpu_force_next = 1'b1;
        end else if (cpu_idle_in) begin
          state_next = pend_hib_reg ? pmc_pkg::PMC_HIB : pmc_pkg::PMC_SLEEP;
        end
      end
      pmc_pkg::PMC_SLEEP: begin
        if (slp_wake) begin
          state_next = pmc_pkg::PMC_SWAKE;
          cnt_next = '0;
        end
      end
      pmc_pkg::PMC_SWAKE: begin
        // Regulators settle before code runs again
        if (cnt_reg == `PMC_CNT_W'(`PMC_SLP_WAKE_CYC - 1)) begin
          state_next = pmc_pkg::PMC_ACT;
          cpu_force_next = 1'b1;
        end else begin
          cnt_next = cnt_reg + `PMC_CNT_W'(1);
        end
      end
      pmc_pkg::PMC_HIB: begin
        if (hib_wake) begin
          state_next = pmc_pkg::PMC_HWAKE;
          cnt_next = '0;
        end
      end
      pmc_pkg::PMC_HWAKE: begin
        if (cnt_reg == `PMC_CNT_W'(`PMC_HIB_RESUME_CYC - 1)) begin
          state_next = pmc_pkg::PMC_ACT;
          cpu_force_next = 1'b1;
        end else begin
          cnt_next = cnt_reg + `PMC_CNT_W'(1);
        end
      end
      default: state_next = pmc_pkg::PMC_ACT;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= pmc_pkg::PMC_ACT;
      cnt_reg <= '0;
      pend_hib_reg <= 1'b0;
      base_alt_reg <= 1'b0;
      cpu_force_reg <= 1'b0;
      wake_len_reg <= 14'h0000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      pend_hib_reg <= pend_hib_next;
      base_alt_reg <= base_alt_next;
      cpu_force_reg <= cpu_force_next;
      wake_len_reg <= wake_len_next;
    end
  end

  // ----------------------------------------------------------------
  // Resource enables, from the next state so a write acts next cycle
  // ----------------------------------------------------------------
  always_comb begin
    case (state_next)
      pmc_pkg::PMC_ACT: en_vec_next = act_tmpl_next;
      pmc_pkg::PMC_ALT: en_vec_next = alt_tmpl_next;
      pmc_pkg::PMC_PEND: en_vec_next = base_alt_next ? alt_tmpl_next : act_tmpl_next;
      default: en_vec_next = '0;
    endcase
    if (cpu_force_next && (state_next == pmc_pkg::PMC_ACT || state_next == pmc_pkg::PMC_ALT)) begin
      en_vec_next[`PMC_CPU_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      en_vec_reg <= `PMC_RST_ACT_TMPL;
    end else begin
      en_vec_reg <= en_vec_next;
    end
  end

  // Clock gate and bias share one enable per resource
  assign res_out.clk_en = en_vec_reg;
  assign res_out.bias_en = en_vec_reg;

  // ----------------------------------------------------------------
  // Register file, interrupt status and outputs
  // ----------------------------------------------------------------
  always_comb begin
    act_tmpl_next = act_tmpl_reg;
    alt_tmpl_next = alt_tmpl_reg;
    reg_ctl_next = reg_ctl_reg;
    tw_ctl_next = tw_ctl_reg;
    int_en_next = int_en_reg;
    int_stat_next = int_stat_reg;
    if (wr_in) begin
      case (addr_in)
        `PMC_A_ACT_TMPL: act_tmpl_next = wdata_in[`PMC_NRES-1:0];
        `PMC_A_ALT_TMPL: alt_tmpl_next = wdata_in[`PMC_NRES-1:0];
        `PMC_A_REG_CTL: reg_ctl_next = wdata_in[1:0];
        `PMC_A_TW_CTL: tw_ctl_next = wdata_in[4:0];
        `PMC_A_INT_EN: int_en_next = wdata_in[`PMC_NINT-1:0];
        `PMC_A_INT_CLR: int_stat_next = int_stat_reg & ~wdata_in[`PMC_NINT-1:0];
        default: ;
      endcase
    end
    // Events set after the clear so a same-cycle event is kept
    int_stat_next = int_stat_next | int_evt;
  end

  assign int_evt[`PMC_INT_SLP_WAKE] = state_reg == pmc_pkg::PMC_SWAKE
    && state_next == pmc_pkg::PMC_ACT;
  assign int_evt[`PMC_INT_HIB_WAKE] = state_reg == pmc_pkg::PMC_HWAKE
    && state_next == pmc_pkg::PMC_ACT;
  assign int_evt[`PMC_INT_TW_TICK] = tw_tick;

  // Read mux; unmapped and write-only offsets read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (rd_in) begin
      case (addr_in)
        `PMC_A_MODE: rdata_next[1:0] = mode_out;
        `PMC_A_ACT_TMPL: rdata_next[`PMC_NRES-1:0] = act_tmpl_reg;
        `PMC_A_ALT_TMPL: rdata_next[`PMC_NRES-1:0] = alt_tmpl_reg;
        `PMC_A_REG_CTL: rdata_next[1:0] = reg_ctl_reg;
        `PMC_A_TW_CTL: rdata_next[4:0] = tw_ctl_reg;
        `PMC_A_TW_CNT: rdata_next[`PMC_TW_W-1:0] = tw_count;
        // Firmware checks supply valid before a low-power request
        `PMC_A_STATUS: rdata_next[1:0] = {cpu_idle_in, io_supply_valid_in};
        `PMC_A_INT_STAT: rdata_next[`PMC_NINT-1:0] = int_stat_reg;
        `PMC_A_INT_EN: rdata_next[`PMC_NINT-1:0] = int_en_reg;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      act_tmpl_reg <= `PMC_RST_ACT_TMPL;
      alt_tmpl_reg <= `PMC_RST_ALT_TMPL;
      reg_ctl_reg <= `PMC_RST_REG_CTL;
      tw_ctl_reg <= `PMC_RST_TW_CTL;
      int_en_reg <= `PMC_RST_INT_EN;
      int_stat_reg <= '0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      act_tmpl_reg <= act_tmpl_next;
      alt_tmpl_reg <= alt_tmpl_next;
      reg_ctl_reg <= reg_ctl_next;
      tw_ctl_reg <= tw_ctl_next;
      int_en_reg <= int_en_next;
      int_stat_reg <= int_stat_next;
      rdata_reg <= rdata_next;
    end
  end

  // Mode code seen by software and by the supply control
  always_comb begin
    case (state_reg)
      pmc_pkg::PMC_ACT: mode_out = `PMC_MODE_ACT;
      pmc_pkg::PMC_ALT: mode_out = `PMC_MODE_ALT;
      pmc_pkg::PMC_PEND: mode_out = base_alt_reg ? `PMC_MODE_ALT : `PMC_MODE_ACT;
      pmc_pkg::PMC_SLEEP, pmc_pkg::PMC_SWAKE: mode_out = `PMC_MODE_SLEEP;
      default: mode_out = `PMC_MODE_HIB;
    endcase
  end

  // Low-speed clocks stop only in hibernate
  assign lso_run_out = mode_out != `PMC_MODE_HIB;
  // Core regulators are dropped in hibernate, both enable bits held low
  assign core_reg_en_out = lso_run_out ? reg_ctl_reg : 2'h0;
  assign irq_out = |(int_stat_reg & int_en_reg);
  assign rdata_out = rdata_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_act_template: assert property (state_reg == pmc_pkg::PMC_ACT && !cpu_force_reg
    && $past(state_reg) == pmc_pkg::PMC_ACT |-> res_out.clk_en == act_tmpl_reg)
    else $error("Active enables differ from template");
  a_gate_bias: assert property (res_out.clk_en == res_out.bias_en)
    else $error("Clock and bias enables disagree");
  a_tmpl_apply: assert property (state_reg == pmc_pkg::PMC_ACT && !irq_any_in && !mode_wr
    && wr_in && addr_in == `PMC_A_ACT_TMPL |=> res_out.clk_en[7:1] == $past(wdata_in[7:1]))
    else $error("Template write not applied");
  a_wake_cpu: assert property ((state_reg == pmc_pkg::PMC_ACT || state_reg == pmc_pkg::PMC_ALT)
    && irq_any_in |=> state_reg == pmc_pkg::PMC_ACT && res_out.clk_en[`PMC_CPU_BIT])
    else $error("Wakeup did not restore active with CPU");
  a_sleep_off: assert property (mode_out == `PMC_MODE_SLEEP |-> res_out.clk_en == '0)
    else $error("Resources enabled in sleep");
  a_slp_wake_time: assert property ($fell(state_reg == pmc_pkg::PMC_SWAKE)
    |-> state_reg == pmc_pkg::PMC_ACT && wake_len_reg == 14'h05dc)
    else $error("Sleep wake interval wrong");
  a_hib_pin_only: assert property (state_reg == pmc_pkg::PMC_HIB && !hib_wake
    |=> state_reg == pmc_pkg::PMC_HIB)
    else $error("Hibernate left without pin interrupt");
  a_hib_resume: assert property (state_reg == pmc_pkg::PMC_HWAKE
    |-> wake_len_reg < 14'h2710)
    else $error("Hibernate resume too slow");
  a_entry_idle: assert property (state_reg == pmc_pkg::PMC_PEND && !cpu_idle_in
    && !irq_any_in |=> state_reg == pmc_pkg::PMC_PEND)
    else $error("Low-power entry without CPU idle");
  a_exit_active: assert property ((mode_out == `PMC_MODE_SLEEP || mode_out == `PMC_MODE_HIB)
    ##1 (mode_out != `PMC_MODE_SLEEP && mode_out != `PMC_MODE_HIB) |-> mode_out == `PMC_MODE_ACT)
    else $error("Low-power exit not to active");

endmodule : pmc_power_mode_controller

/* tb/tb.sv */
// Self-checking testbench of the power mode controller
`timescale 1ns/100ps
`include "pmc_defines.svh"

module tb;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic lso_clk_in = 1'b0;
  logic cpu_idle_in = 1'b0;
  logic irq_any_in = 1'b0;
  logic [4:0] wake_pin_in = 5'h00;
  logic io_supply_valid_in = 1'b1;
  logic [31:0] rdata_out;
  logic [1:0] mode_out;
  pmc_pkg::pmc_res_s res_out;
  logic lso_run_out;
  logic [1:0] core_reg_en_out;
  logic irq_out;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int n;
  logic [31:0] seed = 32'h8404;
  logic [31:0] rd_val;
  // Behavioural model: templates, current mode and the wake-time CPU override
  logic [7:0] m_act = 8'hff;
  logic [7:0] m_alt = 8'hfe;
  logic [1:0] exp_mode = 2'h0;
  logic force_cpu = 1'b0;

  pmc_power_mode_controller pmc_power_mode_controller_i (.clk_in(clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .lso_clk_in(lso_clk_in), .cpu_idle_in(cpu_idle_in),
    .irq_any_in(irq_any_in), .wake_pin_in(wake_pin_in),
    .io_supply_valid_in(io_supply_valid_in), .mode_out(mode_out), .res_out(res_out),
    .lso_run_out(lso_run_out), .core_reg_en_out(core_reg_en_out), .irq_out(irq_out));

  // ----------------------------------------------------------------
  // Clocks and timeout
  // ----------------------------------------------------------------
  always #5 clk_in = ~clk_in;
  // Low-speed clock sped up so the timewheel moves within a short run
  always @(posedge clk_in) begin
    cycles++;
    if (cycles % 10 == 0) lso_clk_in <= ~lso_clk_in;
    if (cycles == 40000) begin
      n_errors++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
      n_errors++;
    end
  endtask : chk

  // One-cycle write; the model follows template writes and mode writes to active or alternate
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    if (a == `PMC_A_ACT_TMPL) {m_act, force_cpu} = {d[7:0], 1'b0};
    if (a == `PMC_A_ALT_TMPL) {m_alt, force_cpu} = {d[7:0], 1'b0};
    if (a == `PMC_A_MODE && d[1] == 1'b0) exp_mode = d[1:0];
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    rd_val = rdata_out;
  endtask : rd

  // Compare mode and resource enables with the model one cycle on
  task automatic state();
    logic [7:0] e;
    @(posedge clk_in);
    #1;
    e = exp_mode == 2'h0 ? m_act | {7'h0, force_cpu} :
        exp_mode == 2'h1 ? m_alt | {7'h0, force_cpu} : 8'h00;
    chk(mode_out, exp_mode, "mode");
    chk(res_out, {e, e}, "resources");
  endtask : state

  task automatic wait_mode(input logic [1:0] m);
    n = 0;
    #1;
    while (mode_out !== m && n < 10000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
  endtask : wait_mode

  // One-cycle interrupt; the model expects active with the CPU forced on
  task automatic irq();
    @(posedge clk_in);
    irq_any_in <= 1'b1;
    @(posedge clk_in);
    irq_any_in <= 1'b0;
    {exp_mode, force_cpu} = {2'h0, 1'b1};
  endtask : irq

  task automatic wrap_up();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    state();
    chk(core_reg_en_out, 2'h3, "regulators after reset");
    rd(`PMC_A_REG_CTL);
    chk(rd_val, 32'h3, "regulator control");
    rd(8'h3c);
    chk(rd_val, 32'h0, "unmapped read");
    // Random active templates apply at once, each bit its own resource
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(`PMC_A_ACT_TMPL, seed);
      state();
    end
    wr(`PMC_A_MODE, 32'h1);
    state();
    seed = lfsr(seed);
    wr(`PMC_A_ALT_TMPL, seed);
    state();
    irq();
    state();
    wr(`PMC_A_MODE, 32'h0);
    state();
    // Sleep: CPU switched off, entry held back until the CPU is idle
    wr(`PMC_A_INT_EN, 32'h3);
    wr(`PMC_A_ACT_TMPL, 32'hfe);
    state();
    wr(`PMC_A_MODE, 32'h2);
    repeat (5) state();
    // An interrupt while entry is pending aborts it back to active
    irq();
    state();
    wr(`PMC_A_MODE, 32'h2);
    @(posedge clk_in);
    cpu_idle_in <= 1'b1;
    exp_mode = 2'h2;
    wait_mode(2'h2);
    state();
    chk(lso_run_out, 1'b1, "low-speed clocks in sleep");
    @(posedge clk_in);
    wake_pin_in <= 5'h01;
    wait_mode(2'h0);
    chk(n >= 1500 && n <= 1510, 1'b1, "sleep wake interval");
    wake_pin_in <= 5'h00;
    {exp_mode, force_cpu} = {2'h0, 1'b1};
    state();
    chk(irq_out, 1'b1, "interrupt after wake");
    rd(`PMC_A_INT_STAT);
    chk(rd_val[1:0], 2'h1, "sleep wake status");
    wr(`PMC_A_INT_CLR, 32'h1);
    state();
    chk(irq_out, 1'b0, "interrupt cleared");
    // Hibernate: only the pin interrupt unit wakes it
    wr(`PMC_A_MODE, 32'h3);
    exp_mode = 2'h3;
    wait_mode(2'h3);
    state();
    chk({lso_run_out, core_reg_en_out}, 3'h0, "clocks and regulators off");
    @(posedge clk_in);
    wake_pin_in <= 5'h1d;
    repeat (50) state();
    @(posedge clk_in);
    wake_pin_in <= 5'h02;
    wait_mode(2'h0);
    chk(n < 10000, 1'b1, "hibernate resume");
    wake_pin_in <= 5'h00;
    {exp_mode, force_cpu} = {2'h0, 1'b1};
    state();
    chk(irq_out, 1'b1, "interrupt after resume");
    // Software may drop the core regulators when supplies come from outside
    wr(`PMC_A_REG_CTL, 32'h0);
    rd(`PMC_A_REG_CTL);
    chk({rd_val[1:0], core_reg_en_out}, 4'h0, "regulators off");
    // Timewheel reset by firmware, then steps on each rising low-speed edge
    wr(`PMC_A_TW_CTL, 32'h20);
    rd(`PMC_A_TW_CNT);
    chk(rd_val <= 32'h1, 1'b1, "timewheel reset");
    repeat (200) @(posedge clk_in);
    rd(`PMC_A_TW_CNT);
    chk(rd_val >= 32'h9 && rd_val <= 32'hc, 1'b1, "timewheel steps");
    wrap_up();
  end
endmodule : tb
